// [shared/fpes_pkg.sv]
package fpes_pkg;

   // register port and address widths
   localparam int unsigned ADDR_W = 4;
   localparam int unsigned DATA_W = 16;
   localparam int unsigned PA_W   = 24;

   // register offsets on the software port
   localparam logic [3:0] OFS_CTRL     = 4'h0;
   localparam logic [3:0] OFS_KEY      = 4'h2;
   localparam logic [3:0] OFS_TBL_PAGE = 4'h4;
   localparam logic [3:0] OFS_VIS_PAGE = 4'h6;

   // control register field positions
   localparam int unsigned BIT_WR    = 15;
   localparam int unsigned BIT_WEN   = 14;
   localparam int unsigned BIT_ERR   = 13;
   localparam int unsigned BIT_ERASE = 6;
   localparam int unsigned OP_MSB    = 3;
   localparam int unsigned OP_LSB    = 0;

   // operation select codes
   localparam logic [3:0] OP_ROW   = 4'h1;
   localparam logic [3:0] OP_ERASE = 4'h2;
   localparam logic [3:0] OP_WORD  = 4'h3;

   // unlock key pair
   localparam logic [7:0] KEY_FIRST  = 8'h55;
   localparam logic [7:0] KEY_SECOND = 8'hAA;

   // reset values
   localparam logic [15:0] CTRL_RST = 16'h0000;
   localparam logic [7:0]  PAGE_RST = 8'h00;

   // flash geometry: instructions per row, rows per erase block
   localparam int unsigned ROW_INSTR  = 64;
   localparam int unsigned BLK_ROWS   = 8;
   localparam int unsigned ROW_LOW    = $clog2(ROW_INSTR * 2);
   localparam int unsigned BLK_LOW    = $clog2(ROW_INSTR * BLK_ROWS * 2);

   // sequencer and unlock states
   typedef enum logic [1:0] {ST_IDLE, ST_ISSUE, ST_WAIT} fpes_state_t;
   typedef enum logic [1:0] {KEY_IDLE, KEY_HALF, KEY_ARMED} fpes_key_t;

endpackage

// [shared/fpes_addr_if.sv]
`timescale 1ns/10ps
interface fpes_addr_if;
   import fpes_pkg::*;
   logic [7:0]      tbl_page;
   logic [7:0]      vis_page;
   logic [15:0]     eff_addr;
   logic            tbl_rd;
   logic            tbl_wr;
   logic            vis_rd;
   logic [PA_W-1:0] addr;
   logic            cfg;
   logic            rd_pulse;
   logic            wr_pulse;
   logic [PA_W-1:0] wr_base;

   // address former side
   modport gen (
      input  tbl_page, vis_page, eff_addr, tbl_rd, tbl_wr, vis_rd,
      output addr, cfg, rd_pulse, wr_pulse, wr_base
   );
   // sequencer side
   modport user (
      output tbl_page, vis_page, eff_addr, tbl_rd, tbl_wr, vis_rd,
      input  addr, cfg, rd_pulse, wr_pulse, wr_base
   );
endinterface

// [rtl/fpes_addr_gen.sv]
`timescale 1ns/10ps
module fpes_addr_gen
   import fpes_pkg::*;
(
   // clock and reset
   input wire logic i_mclk,
   input wire logic i_rst,
   // address request and result
   fpes_addr_if.gen a
);

   logic [PA_W-1:0] addr_q;
   logic            cfg_q;
   logic            rd_q;
   logic            wr_q;
   logic [PA_W-1:0] base_q;
   wire  [PA_W-1:0] tbl_addr;
   wire  [PA_W-1:0] vis_addr;
   wire  [PA_W-1:0] addr_d;

   // page above full address, no alignment forced
   assign tbl_addr = {a.tbl_page, a.eff_addr};
   // window read drops address bit 15, page bit 0 takes its place
   assign vis_addr = {1'b0, a.vis_page[7:1], a.vis_page[0], a.eff_addr[14:0]};
   assign addr_d   = a.vis_rd ? vis_addr : tbl_addr;

   // register the formed address and strobes
   always_ff @(posedge i_mclk) begin
      if (i_rst) begin
         addr_q <= '0;
         cfg_q  <= 1'b0;
         rd_q   <= 1'b0;
         wr_q   <= 1'b0;
         base_q <= '0;
      end else begin
         rd_q <= a.tbl_rd | a.vis_rd; // reads in both spaces
         wr_q <= a.tbl_wr;
         if (a.tbl_rd | a.tbl_wr | a.vis_rd) begin
            addr_q <= addr_d;
            cfg_q  <= ~a.vis_rd & a.tbl_page[7]; // top page bit
         end
         if (a.tbl_wr) begin
            base_q <= tbl_addr;
         end
      end
   end

   assign a.addr     = addr_q;
   assign a.cfg      = cfg_q;
   assign a.rd_pulse = rd_q;
   assign a.wr_pulse = wr_q;
   assign a.wr_base  = base_q;

   default clocking cb @(posedge i_mclk); endclocking
   default disable iff (i_rst);

   chk_vis_page_bit: assert property (
      a.vis_rd |=> addr_q[15] == $past(a.vis_page[0]) && !addr_q[23]
         && addr_q[14:0] == $past(a.eff_addr[14:0]))
      else $error("window address not formed from page bit 0");
   chk_table_concat: assert property (
      (a.tbl_rd || a.tbl_wr) && !a.vis_rd
         |=> addr_q == {$past(a.tbl_page), $past(a.eff_addr)}
         && cfg_q == $past(a.tbl_page[7]))
      else $error("table address not page over offset");
   chk_cfg_read_ok: assert property (
      a.tbl_rd && a.tbl_page[7] && !a.vis_rd |=> rd_q && cfg_q)
      else $error("configuration space read refused");
   chk_odd_address: assert property (
      (a.tbl_rd || a.tbl_wr) && a.eff_addr[0] && !a.vis_rd |=> addr_q[0])
      else $error("table access forced to alignment");

   cov_cfg_read: cover property (a.tbl_rd && a.tbl_page[7]);
endmodule

// [rtl/fpes_top.sv]
// The register offsets and the plain strobed port were left to the implementer.
`timescale 1ns/10ps
// Summary of operation
// - erase needs erase flag bit 6 and write enable bit 14 set
// - start bit 15 after valid unlock begins cycle, processor stalls
// - erase completion clears the start bit in hardware
// - row program completion clears start bit and ends the stall
// - erase unit is an eight-row block of 512 instructions
// - one row program writes 64 instructions from the buffers
// - table accesses need not be word aligned
// - table reads may reach configuration space
// - window read uses page bit 0 as address bit 15
module fpes_top
   import fpes_pkg::*;
(
   // clock and reset
   input  wire logic              i_mclk,
   input  wire logic              i_rst,
   // register port
   input  wire logic [ADDR_W-1:0] i_addr,
   input  wire logic [DATA_W-1:0] i_wdata,
   input  wire logic              i_wr,
   input  wire logic              i_rd,
   output logic      [DATA_W-1:0] o_rdata,
   // table access from the processor
   input  wire logic [15:0]       i_eff_addr,
   input  wire logic              i_tbl_rd,
   input  wire logic              i_tbl_wr,
   input  wire logic              i_tbl_hi,
   input  wire logic [15:0]       i_tbl_wdata,
   input  wire logic              i_vis_rd,
   // table access toward the flash array
   output logic      [PA_W-1:0]   o_tbl_addr,
   output logic                   o_tbl_cfg,
   output logic                   o_tbl_rd,
   output logic                   o_tbl_wr,
   output logic                   o_tbl_hi,
   output logic      [15:0]       o_tbl_wdata,
   // flash commands
   output logic                   o_fl_erase,
   output logic                   o_fl_row,
   output logic                   o_fl_word,
   output logic      [PA_W-1:0]   o_fl_addr,
   input  wire logic              i_fl_done,
   // processor stall
   output logic                   o_cpu_stall
);

   function automatic logic hit(input logic [ADDR_W-1:0] adr,
                                input logic [3:0] ofs);
      hit = (adr == ofs);
   endfunction

   fpes_state_t     state_q;
   fpes_state_t     state_d;
   fpes_key_t       key_q;
   fpes_key_t       key_d;
   logic [15:0]     ctrl_q;
   logic [15:0]     ctrl_d;
   logic [7:0]      tbl_page_q;
   logic [7:0]      vis_page_q;
   logic [15:0]     rdata_q;
   logic            stall_q;
   logic            erase_q;
   logic            row_q;
   logic            word_q;
   logic [PA_W-1:0] fl_addr_q;
   logic [PA_W-1:0] fl_addr_d;
   logic            hi_q;
   logic [15:0]     wdata_q;

   fpes_addr_if ai ();

   // register decode
   wire wr_ctrl = i_wr & hit(i_addr, OFS_CTRL);
   wire wr_key  = i_wr & hit(i_addr, OFS_KEY);
   wire wr_tpg  = i_wr & hit(i_addr, OFS_TBL_PAGE);
   wire wr_ppg  = i_wr & hit(i_addr, OFS_VIS_PAGE);
   wire [3:0] w_op  = i_wdata[OP_MSB:OP_LSB];
   wire [3:0] op_q  = ctrl_q[OP_MSB:OP_LSB];
   wire       idle  = (state_q == ST_IDLE);

   // operation checks on the written control value
   wire op_erase = (w_op == OP_ERASE) & i_wdata[BIT_ERASE];
   wire op_row   = (w_op == OP_ROW) & ~i_wdata[BIT_ERASE];
   wire op_word  = (w_op == OP_WORD);
   wire op_ok    = i_wdata[BIT_WEN] & (op_erase | op_row | op_word);
   wire go_req   = wr_ctrl & i_wdata[BIT_WR] & idle;
   // start only straight after the key pair
   wire start    = go_req & (key_q == KEY_ARMED) & op_ok;
   wire refuse   = go_req & ~start;
   wire done     = (state_q == ST_WAIT) & i_fl_done;

   // unlock tracker: any other write breaks the sequence
   always_comb begin
      key_d = key_q;
      if (i_wr) begin
         if (wr_key && i_wdata[7:0] == KEY_FIRST) begin
            key_d = KEY_HALF;
         end else if (wr_key && i_wdata[7:0] == KEY_SECOND
                      && key_q == KEY_HALF) begin
            key_d = KEY_ARMED;
         end else begin
            key_d = KEY_IDLE;
         end
      end
   end

   // control register next value
   always_comb begin
      ctrl_d = ctrl_q;
      if (wr_ctrl && idle) begin
         ctrl_d[OP_MSB:OP_LSB] = w_op;
         ctrl_d[BIT_ERASE]     = i_wdata[BIT_ERASE];
         ctrl_d[BIT_WEN]       = i_wdata[BIT_WEN];
         ctrl_d[BIT_ERR]       = ctrl_q[BIT_ERR] & i_wdata[BIT_ERR];
      end
      if (start) begin
         ctrl_d[BIT_WR] = 1'b1;
      end
      if (refuse) begin
         ctrl_d[BIT_ERR] = 1'b1; // set wins over the clear
      end
      if (done) begin
         ctrl_d[BIT_WR] = 1'b0;
      end
   end

   // sequencer: issue one command, then wait for the array
   always_comb begin
      state_d = state_q;
      unique case (state_q)
         ST_IDLE: begin
            if (start) begin
               state_d = ST_ISSUE;
            end
         end
         ST_ISSUE: begin
            state_d = ST_WAIT;
         end
         ST_WAIT: begin
            if (i_fl_done) begin
               state_d = ST_IDLE;
            end
         end
      endcase
   end

   // target address: block, row or word from last table write
   always_comb begin
      fl_addr_d = ai.wr_base;
      unique case (op_q)
         OP_ERASE: fl_addr_d[BLK_LOW-1:0] = '0;
         OP_ROW:   fl_addr_d[ROW_LOW-1:0] = '0;
         default:  fl_addr_d = ai.wr_base;
      endcase
   end

   // sequencer registers
   always_ff @(posedge i_mclk) begin
      if (i_rst) begin
         state_q <= ST_IDLE;
         key_q   <= KEY_IDLE;
         ctrl_q  <= CTRL_RST;
         stall_q <= 1'b0;
      end else begin
         state_q <= state_d;
         key_q   <= key_d;
         ctrl_q  <= ctrl_d;
         stall_q <= (state_d != ST_IDLE);
      end
   end

   // flash command pulses, issued two cycles after the start
   always_ff @(posedge i_mclk) begin
      if (i_rst) begin
         erase_q   <= 1'b0;
         row_q     <= 1'b0;
         word_q    <= 1'b0;
         fl_addr_q <= '0;
      end else begin
         erase_q <= (state_q == ST_ISSUE) & (op_q == OP_ERASE);
         row_q   <= (state_q == ST_ISSUE) & (op_q == OP_ROW);
         word_q  <= (state_q == ST_ISSUE) & (op_q == OP_WORD);
         if (state_q == ST_ISSUE) begin
            fl_addr_q <= fl_addr_d;
         end
      end
   end

   // page registers and read port
   always_ff @(posedge i_mclk) begin
      if (i_rst) begin
         tbl_page_q <= PAGE_RST;
         vis_page_q <= PAGE_RST;
         rdata_q    <= '0;
      end else begin
         if (wr_tpg) begin
            tbl_page_q <= i_wdata[7:0];
         end
         if (wr_ppg) begin
            vis_page_q <= i_wdata[7:0];
         end
         rdata_q <= '0;
         if (i_rd && hit(i_addr, OFS_CTRL)) begin
            rdata_q <= ctrl_q;
         end else if (i_rd && hit(i_addr, OFS_TBL_PAGE)) begin
            rdata_q <= {8'h00, tbl_page_q};
         end else if (i_rd && hit(i_addr, OFS_VIS_PAGE)) begin
            rdata_q <= {8'h00, vis_page_q};
         end
      end
   end

   // table write data is registered in the same cycle as the address stage
   always_ff @(posedge i_mclk) begin
      if (i_rst) begin
         hi_q    <= 1'b0;
         wdata_q <= '0;
      end else if (i_tbl_wr) begin
         hi_q    <= i_tbl_hi;
         wdata_q <= i_tbl_wdata;
      end
   end

   // address former
   assign ai.tbl_page = tbl_page_q;
   assign ai.vis_page = vis_page_q;
   assign ai.eff_addr = i_eff_addr;
   assign ai.tbl_rd   = i_tbl_rd;
   assign ai.tbl_wr   = i_tbl_wr;
   assign ai.vis_rd   = i_vis_rd;

   fpes_addr_gen u_addr (
      .i_mclk (i_mclk),
      .i_rst  (i_rst),
      .a      (ai.gen)
   );

   // outputs
   assign o_rdata     = rdata_q;
   assign o_tbl_addr  = ai.addr;
   assign o_tbl_cfg   = ai.cfg;
   assign o_tbl_rd    = ai.rd_pulse;
   assign o_tbl_wr    = ai.wr_pulse;
   assign o_tbl_hi    = hi_q;
   assign o_tbl_wdata = wdata_q;
   assign o_fl_erase  = erase_q;
   assign o_fl_row    = row_q;
   assign o_fl_word   = word_q;
   assign o_fl_addr   = fl_addr_q;
   assign o_cpu_stall = stall_q;

   default clocking cb @(posedge i_mclk); endclocking
   default disable iff (i_rst);

   chk_erase_flags: assert property (
      erase_q |-> ctrl_q[BIT_ERASE] && ctrl_q[BIT_WEN] && ctrl_q[BIT_WR])
      else $error("erase issued without erase and enable flags");
   chk_start_stalls: assert property (
      start |=> (stall_q && ctrl_q[BIT_WR])[*2])
      else $error("start did not stall the processor");
   chk_erase_ends: assert property (
      done && op_q == OP_ERASE |=> !ctrl_q[BIT_WR] && !stall_q)
      else $error("erase end did not clear start bit");
   chk_row_ends: assert property (
      done && op_q == OP_ROW |=> !ctrl_q[BIT_WR] && !stall_q)
      else $error("row end did not clear start bit or stall");
   chk_block_align: assert property (
      erase_q |-> o_fl_addr[BLK_LOW-1:0] == '0)
      else $error("erase address not block aligned");
   chk_row_align: assert property (
      row_q |-> o_fl_addr[ROW_LOW-1:0] == '0)
      else $error("row address not row aligned");
   chk_no_key_start: assert property (
      go_req && key_q != KEY_ARMED
         |=> !stall_q && ctrl_q[BIT_ERR] ##1 !erase_q && !row_q && !word_q)
      else $error("cycle started without unlock");

   cov_erase: cover property (erase_q);
   cov_row: cover property (row_q ##[1:50] !stall_q);
   cov_word: cover property (word_q);
   cov_refused: cover property (refuse);
endmodule

// [bench/fpes_flash_model.sv]
`timescale 1ns/10ps
module fpes_flash_model (
   // clock and reset
   input  wire logic       i_mclk,
   input  wire logic       i_rst,
   // command seen and busy time
   input  wire logic       i_go,
   input  wire logic [7:0] i_delay,
   // completion pulse
   output logic            o_done
);
   logic [7:0] cnt_q;

   // busy countdown, done pulses once when it runs out
   always_ff @(posedge i_mclk) begin
      if (i_rst) begin
         cnt_q  <= 8'h00;
         o_done <= 1'b0;
      end else begin
         o_done <= (cnt_q == 8'h01);
         if (i_go)
            cnt_q <= i_delay;
         else if (cnt_q != 8'h00)
            cnt_q <= cnt_q - 8'h01;
      end
   end
endmodule

// [bench/fpes_top_tb_top.sv]
`timescale 1ns/10ps
module fpes_top_tb_top;
   import fpes_pkg::*;
   logic              i_mclk, i_rst, i_wr, i_rd, i_fl_done;
   logic [ADDR_W-1:0] i_addr;
   logic [DATA_W-1:0] i_wdata, o_rdata;
   logic              i_tbl_rd, i_tbl_wr, i_tbl_hi, i_vis_rd;
   logic [15:0]       i_eff_addr, i_tbl_wdata, o_tbl_wdata, r, base;
   logic [PA_W-1:0]   o_tbl_addr, o_fl_addr;
   logic              o_tbl_cfg, o_tbl_rd, o_tbl_wr, o_tbl_hi;
   logic              o_fl_erase, o_fl_row, o_fl_word, o_cpu_stall;
   logic [7:0]        dly, pg;
   logic [31:0]       bad [6];
   int                num_errors, n_tests, n_cmd, seed;

   fpes_top i_dut (.i_mclk, .i_rst, .i_addr, .i_wdata, .i_wr, .i_rd,
      .o_rdata, .i_eff_addr, .i_tbl_rd, .i_tbl_wr, .i_tbl_hi, .i_tbl_wdata,
      .i_vis_rd, .o_tbl_addr, .o_tbl_cfg, .o_tbl_rd, .o_tbl_wr,
      .o_tbl_hi, .o_tbl_wdata, .o_fl_erase, .o_fl_row, .o_fl_word,
      .o_fl_addr, .i_fl_done, .o_cpu_stall);

   fpes_flash_model i_flash (.i_mclk, .i_rst,
      .i_go(o_fl_erase | o_fl_row | o_fl_word), .i_delay(dly),
      .o_done(i_fl_done));

   // clock and command pulse counter
   initial begin
      i_mclk = 1'b0;
      forever #4 i_mclk = ~i_mclk;
   end
   always @(posedge i_mclk)
      if (o_fl_erase | o_fl_row | o_fl_word) n_cmd++;

   task automatic chk(input logic [31:0] g, input logic [31:0] e);
      n_tests++;
      if (g !== e) begin
         num_errors++;
         $display("[ERR] t=%0t got=%h exp=%h", $time, g, e);
      end
   endtask

   task automatic complete_run;
      $display("checks %0d mismatches %0d", n_tests, num_errors);
      if (num_errors == 0 && n_tests > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask

   // register port strobes, set just after an edge
   task automatic wr(input logic [3:0] a, input logic [15:0] d);
      i_addr  <= a;
      i_wdata <= d;
      i_wr    <= 1'b1;
      i_rd    <= 1'b0;
      @(posedge i_mclk);
   endtask
   task automatic rd(input logic [3:0] a, output logic [15:0] d);
      i_addr <= a;
      i_rd   <= 1'b1;
      i_wr   <= 1'b0;
      @(posedge i_mclk);
      i_rd <= 1'b0;
      #1 d = o_rdata;
   endtask

   // expected program address: window or page over offset
   function automatic logic [23:0] exp_addr(input logic [1:0] k,
      input logic [7:0] p, input logic [15:0] e);
      exp_addr = (k == 2'd2) ? {1'b0, p, e[14:0]} : {p, e};
   endfunction

   // table access: 0 write, 1 read, 2 window read
   task automatic tbl(input logic [1:0] k, input logic [7:0] p,
                      input logic [15:0] e);
      logic [15:0] d;
      logic        h;
      d = 16'($random(seed));
      h = d[5];
      wr(k == 2'd2 ? OFS_VIS_PAGE : OFS_TBL_PAGE, {8'h00, p});
      i_wr        <= 1'b0;
      i_eff_addr  <= e;
      i_tbl_wr    <= (k == 2'd0);
      i_tbl_rd    <= (k == 2'd1);
      i_vis_rd    <= (k == 2'd2);
      i_tbl_hi    <= h;
      i_tbl_wdata <= d;
      @(posedge i_mclk);
      i_tbl_wr <= 1'b0;
      i_tbl_rd <= 1'b0;
      i_vis_rd <= 1'b0;
      #1;
      if (k == 2'd2)
         chk(o_tbl_addr, exp_addr(k, p, e));
      else
         chk(o_tbl_addr, exp_addr(k, p, e));
      chk(o_tbl_cfg, k != 2'd2 && p[7]);
      chk({o_tbl_rd, o_tbl_wr}, {k != 2'd0, k == 2'd0});
      if (k == 2'd0)
         chk({o_tbl_hi, o_tbl_wdata}, {h, d});
   endtask

   // key pair, start write, then follow the cycle to its end
   task automatic cmd(input logic [7:0] k1, input logic [7:0] k2,
      input logic [15:0] c, input logic [2:0] p, input logic [23:0] a);
      int n0;
      int n;
      n0 = n_cmd;
      wr(OFS_KEY, {8'h00, k1});
      wr(OFS_KEY, {8'h00, k2});
      wr(OFS_CTRL, c);
      i_wr <= 1'b0;
      #1 chk(o_cpu_stall, p != 3'b000);
      @(posedge i_mclk);
      #1 chk({o_fl_erase, o_fl_row, o_fl_word}, p);
      if (p != 3'b000)
         chk(o_fl_addr, a);
      @(posedge i_mclk); // two quiet slots after the start write
      if (p != 3'b000 && dly > 8'h06) begin
         rd(OFS_CTRL, r);
         chk(r[15], 1'b1);
         wr(OFS_CTRL, 16'h0000);
         rd(OFS_CTRL, r);
         chk(r[15], 1'b1);
      end
      n = 0;
      while (o_cpu_stall !== 1'b0 && n < 400) begin
         @(posedge i_mclk);
         #1 n++;
      end
      if (n >= 400) begin
         chk(32'h0, 32'h1);
         complete_run();
      end
      rd(OFS_CTRL, r);
      chk(r[15], 1'b0);
      chk(r[13], p == 3'b000);
      chk(n_cmd - n0, p != 3'b000);
      wr(OFS_CTRL, 16'h0000);
      rd(OFS_CTRL, r);
   endtask

   // main sequence
   initial begin
      seed = 32'h1cf3;
      {i_rst, i_wr, i_rd, i_tbl_rd, i_tbl_wr, i_tbl_hi, i_vis_rd} = 7'h40;
      {i_addr, i_wdata, i_eff_addr, i_tbl_wdata} = '0;
      {num_errors, n_tests, n_cmd} = '0;
      dly = 8'h14;
      bad = '{32'h5533C042, 32'hAA55C001, 32'h55AA8042,
              32'h55AAC002, 32'h55AAC041, 32'h55AAC000};
      repeat (5) @(posedge i_mclk);
      i_rst <= 1'b0;
      for (int a = 0; a < 16; a += 2) begin
         rd(4'(a), r);
         chk(r, 16'h0000);
      end
      wr(OFS_TBL_PAGE, 16'hFFFF);
      rd(OFS_TBL_PAGE, r);
      chk(r, 16'h00FF);
      $display("test reset and pages done");
      tbl(2'd1, 8'h80, 16'h0001);
      tbl(2'd2, 8'hFF, 16'hFFFF);
      for (int i = 0; i < 60; i++)
         tbl(2'(i % 3), 8'($random(seed)), 16'($random(seed)));
      $display("test table address done");
      pg = 8'($random(seed));
      base = 16'($random(seed)) & 16'hFC00;
      tbl(2'd0, pg, base | 16'h0155);
      cmd(KEY_FIRST, KEY_SECOND, 16'hC042, 3'b100, {pg, base});
      $display("test erase done");
      for (int w = 0; w < 8; w++) begin
         for (int j = 0; j < 64; j++)
            tbl(2'd0, pg, base + 16'(w * 128 + j * 2));
         dly = (w == 0) ? 8'h01 : 8'h02 + 8'($random(seed) & 31);
         cmd(8'h55, 8'hAA, 16'hC001, 3'b010,
             {pg, base + 16'(w * 128)});
      end
      $display("test row writes done");
      tbl(2'd0, pg, base | 16'h0033);
      cmd(8'h55, 8'hAA, 16'hC003, 3'b001, {pg, base | 16'h0033});
      for (int i = 0; i < 10; i++) begin
         r = (i < 6) ? bad[i][15:0] : {12'hC00, 4'h8 | 4'($random(seed))};
         cmd(i < 6 ? bad[i][31:24] : 8'h55,
             i < 6 ? bad[i][23:16] : 8'hAA, r, 3'b000, 24'h0);
      end
      $display("test refused starts done");
      complete_run();
   end
endmodule
